// file: rtl/pdr_pkg.sv
package pdr_pkg;

    // Register indices on the serial register port
    localparam logic [5:0] OFS_PERIOD = 6'h18;
    localparam logic [5:0] OFS_DUTY_A = 6'h19;
    localparam logic [5:0] OFS_DUTY_B = 6'h1A;
    localparam logic [5:0] OFS_DUTY_C = 6'h1B;
    localparam logic [5:0] OFS_DRIVE = 6'h1C;

    // Field layout
    localparam int DUTY_W = 12;
    localparam int PARITY_POS = 15;
    localparam int SEL_W = 3;
    localparam int SEL_A_POS = 0;
    localparam int SEL_B_POS = 4;
    localparam int SEL_C_POS = 8;

    // Reset values
    localparam logic [15:0] RST_PERIOD = 16'h0000;
    localparam logic [15:0] RST_DUTY = 16'h0000;
    localparam logic [15:0] RST_DRIVE = 16'h0777;

    // Drive select codes of one phase
    typedef enum logic [2:0] {
        SEL_OFF = 3'h0,
        SEL_LS_ON = 3'h1,
        SEL_HS_ON = 3'h2,
        SEL_RSVD3 = 3'h3,
        SEL_RSVD4 = 3'h4,
        SEL_LS_PWM = 3'h5,
        SEL_HS_PWM = 3'h6,
        SEL_HS_PWM_LS_INV = 3'h7
    } pdr_sel_type;

    // Gate drive pair of one half bridge
    typedef struct packed {
        logic hs;
        logic ls;
    } pdr_gate_type;

    // Parity bit placed in bit 15: makes the whole word even
    function automatic logic pdr_parity(input logic [14:0] bits);
        pdr_parity = ^bits;
    endfunction : pdr_parity

endpackage : pdr_pkg

// file: rtl/pdr_phase.sv
`timescale 1ns/1ns
`default_nettype none

module pdr_phase #(
    parameter int CNT_W = 12
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Generator state
    input wire logic gen_enable,
    input wire logic [CNT_W-1:0] count,
    input wire logic [CNT_W-1:0] duty,
    input wire logic [2:0] drive_select,
    // Gate outputs
    output pdr_pkg::pdr_gate_type gate
);

    logic pwm;
    pdr_pkg::pdr_gate_type nxt_gate;

    // Elaboration check: the comparator needs at least one counter bit
    if (CNT_W < 1) begin : g_bad_cnt_w
        $error("pdr_phase: CNT_W must be at least 1");
    end

    // Active while the counter is below the duty value
    assign pwm = gen_enable && (count < duty); // [R9]

    // Decode of the drive select; reserved codes keep both sides off for safety
    always_comb begin
        nxt_gate = '0;
        if (gen_enable) begin
            unique case (pdr_pkg::pdr_sel_type'(drive_select)) // [R8]
                pdr_pkg::SEL_OFF: nxt_gate = '0;
                pdr_pkg::SEL_LS_ON: nxt_gate.ls = 1'b1;
                pdr_pkg::SEL_HS_ON: nxt_gate.hs = 1'b1;
                pdr_pkg::SEL_RSVD3: nxt_gate = '0;
                pdr_pkg::SEL_RSVD4: nxt_gate = '0;
                pdr_pkg::SEL_LS_PWM: nxt_gate.ls = pwm;
                pdr_pkg::SEL_HS_PWM: nxt_gate.hs = pwm;
                pdr_pkg::SEL_HS_PWM_LS_INV: begin
                    nxt_gate.hs = pwm;
                    nxt_gate.ls = !pwm; // No dead time is inserted here
                end
            endcase
        end
    end

    // Registered gate drive
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            gate <= '0;
        end else begin
            gate <= nxt_gate;
        end
    end

endmodule : pdr_phase

`default_nettype wire

// file: rtl/pdr_top.sv
// Operation
// [R1] The phase-B word keeps a 12-bit writable duty in bits 11..0, zero after reset, driving phase B.
// [R2] The phase-C word keeps a 12-bit writable duty in bits 11..0, zero after reset, driving phase C.
// [R3] Bit 15 of each duty word is read only and returns parity when the check enable is one, else zero.
// [R4] The phase-B duty word sits at index 1Ah and resets to 0000h.
// [R5] The phase-C duty word sits at index 1Bh and resets to 0000h.
// [R6] The drive select word sits at index 1Ch and resets to 0777h.
// [R7] A 12-bit writable period in bits 11..0 sets the period of all generated outputs.
// [R8] Each phase's 3-bit select gives off, low on, high on, low PWM, high PWM or high PWM with inverted low.
// [R9] Each phase compares a counter wrapping at the period against its duty.
`timescale 1ns/1ns
`default_nettype none

module pdr_top #(
    parameter int CNT_W = 12
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Register port from the serial interface
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // Mode controls
    input wire logic serial_check_enable,
    input wire logic gen_enable,
    // Gate drives
    output pdr_pkg::pdr_gate_type gate_a,
    output pdr_pkg::pdr_gate_type gate_b,
    output pdr_pkg::pdr_gate_type gate_c
);

    // Elaboration check: the field must leave bit 15 free for the parity bit
    if (CNT_W < 1 || CNT_W > 12) begin : g_bad_cnt_w
        $error("pdr_top: CNT_W must lie in 1..12");
    end

    // Bit positions of the words in the one-hot hit vectors
    localparam int HIT_PERIOD = 0;
    localparam int HIT_DUTY_A = 1;
    localparam int HIT_DUTY_B = 2;
    localparam int HIT_DUTY_C = 3;
    localparam int HIT_DRIVE = 4;
    localparam int HIT_W = 5;

    // Index decode shared by the write strobes and the read mux
    // Unmapped indices hit nothing, so writes there are dropped and reads return zero
    function automatic logic [HIT_W-1:0] decode_index(input logic [5:0] addr);
        decode_index = '0;
        unique case (addr)
            pdr_pkg::OFS_PERIOD: decode_index[HIT_PERIOD] = 1'b1;
            pdr_pkg::OFS_DUTY_A: decode_index[HIT_DUTY_A] = 1'b1;
            pdr_pkg::OFS_DUTY_B: decode_index[HIT_DUTY_B] = 1'b1; // [R4]
            pdr_pkg::OFS_DUTY_C: decode_index[HIT_DUTY_C] = 1'b1; // [R5]
            pdr_pkg::OFS_DRIVE: decode_index[HIT_DRIVE] = 1'b1; // [R6]
            default: decode_index = '0; // Other indices belong to neighbouring logic
        endcase
    endfunction : decode_index

    logic [CNT_W-1:0] output_period_ff;
    logic [CNT_W-1:0] phase_a_duty_ff;
    logic [CNT_W-1:0] phase_b_duty_ff;
    logic [CNT_W-1:0] phase_c_duty_ff;
    logic [2:0] phase_a_drive_select_ff;
    logic [2:0] phase_b_drive_select_ff;
    logic [2:0] phase_c_drive_select_ff;
    logic [CNT_W-1:0] count_ff;
    logic [HIT_W-1:0] wr_hit;
    logic [HIT_W-1:0] rd_hit;
    logic cnt_wrap;
    logic [14:0] rd_bits;
    logic [15:0] nxt_rdata;

    // Write strobes per word; the index alone selects the read word
    assign wr_hit = reg_wr ? decode_index(reg_addr) : '0;
    // The read strobe only gates the capture into the answer register
    assign rd_hit = decode_index(reg_addr);

    // Period word; reserved bits of the write data are dropped
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            output_period_ff <= pdr_pkg::RST_PERIOD[CNT_W-1:0];
        end else if (wr_hit[HIT_PERIOD]) begin
            output_period_ff <= reg_wdata[CNT_W-1:0]; // [R7]
        end
    end

    // Phase A duty word
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            phase_a_duty_ff <= pdr_pkg::RST_DUTY[CNT_W-1:0];
        end else if (wr_hit[HIT_DUTY_A]) begin
            phase_a_duty_ff <= reg_wdata[CNT_W-1:0];
        end
    end

    // Phase B duty word
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            phase_b_duty_ff <= pdr_pkg::RST_DUTY[CNT_W-1:0]; // [R1] [R4]
        end else if (wr_hit[HIT_DUTY_B]) begin
            phase_b_duty_ff <= reg_wdata[CNT_W-1:0]; // [R1] [R4]
        end
    end

    // Phase C duty word
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            phase_c_duty_ff <= pdr_pkg::RST_DUTY[CNT_W-1:0]; // [R2] [R5]
        end else if (wr_hit[HIT_DUTY_C]) begin
            phase_c_duty_ff <= reg_wdata[CNT_W-1:0]; // [R2] [R5]
        end
    end

    // Drive selects of the three phases share one word
    // Reserved codes are stored as written; the phase decoder keeps both sides off for them
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            phase_a_drive_select_ff <= pdr_pkg::RST_DRIVE[pdr_pkg::SEL_A_POS +: pdr_pkg::SEL_W]; // [R6]
            phase_b_drive_select_ff <= pdr_pkg::RST_DRIVE[pdr_pkg::SEL_B_POS +: pdr_pkg::SEL_W]; // [R6]
            phase_c_drive_select_ff <= pdr_pkg::RST_DRIVE[pdr_pkg::SEL_C_POS +: pdr_pkg::SEL_W]; // [R6]
        end else if (wr_hit[HIT_DRIVE]) begin // [R6]
            phase_a_drive_select_ff <= reg_wdata[pdr_pkg::SEL_A_POS +: pdr_pkg::SEL_W];
            phase_b_drive_select_ff <= reg_wdata[pdr_pkg::SEL_B_POS +: pdr_pkg::SEL_W];
            phase_c_drive_select_ff <= reg_wdata[pdr_pkg::SEL_C_POS +: pdr_pkg::SEL_W];
        end
    end

    // Read mux, low bits only, reserved bits as zero
    always_comb begin
        rd_bits = '0;
        if (rd_hit[HIT_PERIOD]) begin
            rd_bits[CNT_W-1:0] = output_period_ff;
        end
        if (rd_hit[HIT_DUTY_A]) begin
            rd_bits[CNT_W-1:0] = phase_a_duty_ff;
        end
        if (rd_hit[HIT_DUTY_B]) begin
            rd_bits[CNT_W-1:0] = phase_b_duty_ff; // [R1]
        end
        if (rd_hit[HIT_DUTY_C]) begin
            rd_bits[CNT_W-1:0] = phase_c_duty_ff; // [R2]
        end
        if (rd_hit[HIT_DRIVE]) begin
            rd_bits[pdr_pkg::SEL_A_POS +: pdr_pkg::SEL_W] = phase_a_drive_select_ff;
            rd_bits[pdr_pkg::SEL_B_POS +: pdr_pkg::SEL_W] = phase_b_drive_select_ff;
            rd_bits[pdr_pkg::SEL_C_POS +: pdr_pkg::SEL_W] = phase_c_drive_select_ff;
        end
        nxt_rdata = {1'b0, rd_bits};
        // Parity is computed at read time, so with the check enabled it always matches the word sent
        nxt_rdata[pdr_pkg::PARITY_POS] = serial_check_enable && pdr_pkg::pdr_parity(rd_bits); // [R3]
    end

    // Read valid pulses in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    // Read data is captured only on a read, so it holds until the next one
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= nxt_rdata;
        end
    end

    // Last count of a period; a zero period keeps the counter at zero
    assign cnt_wrap = (output_period_ff == '0) || (count_ff >= output_period_ff - 1'b1); // [R7]

    // Free-running counter 0..period-1, stopped at zero outside generation mode
    // No shadow register: a new period or duty acts within the running period
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            count_ff <= '0;
        end else if (!gen_enable || cnt_wrap) begin
            count_ff <= '0; // [R9] [R7]
        end else begin
            count_ff <= count_ff + 1'b1; // [R9]
        end
    end

    // One comparator and decoder per half bridge
    pdr_phase #(.CNT_W(CNT_W)) u_phase_a (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .gen_enable(gen_enable),
        .count(count_ff),
        .duty(phase_a_duty_ff),
        .drive_select(phase_a_drive_select_ff),
        .gate(gate_a)
    );

    // Phase B half bridge
    pdr_phase #(.CNT_W(CNT_W)) u_phase_b (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .gen_enable(gen_enable),
        .count(count_ff),
        .duty(phase_b_duty_ff), // [R1]
        .drive_select(phase_b_drive_select_ff),
        .gate(gate_b)
    );

    // Phase C half bridge
    pdr_phase #(.CNT_W(CNT_W)) u_phase_c (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .gen_enable(gen_enable),
        .count(count_ff),
        .duty(phase_c_duty_ff), // [R2]
        .drive_select(phase_c_drive_select_ff),
        .gate(gate_c)
    );

endmodule : pdr_top

`default_nettype wire

// file: sim/pdr_top_monitor.sv
`timescale 1ns/1ns
`default_nettype none

module pdr_top_monitor #(
    parameter int CNT_W = 12
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Register port
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    // Mode controls
    input wire logic serial_check_enable,
    input wire logic gen_enable,
    // Gate drives
    input wire pdr_pkg::pdr_gate_type gate_a,
    input wire pdr_pkg::pdr_gate_type gate_b,
    input wire pdr_pkg::pdr_gate_type gate_c
);
    // One domain, so one clocking and one reset guard
    default clocking mon_cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // Read of a 12-bit duty or period word
    wire logic duty_rd = reg_rd && reg_addr >= 6'h18 && reg_addr <= 6'h1B;

    AST_RVALID_PULSE: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
    AST_RVALID_ONLY: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read valid");
    AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
    AST_DUTY_RSVD: assert property (duty_rd |=> reg_rdata[14:12] == 3'h0)
        else $error("duty spare bits set");
    AST_PARITY_OFF: assert property (reg_rd && !serial_check_enable |=> !reg_rdata[15])
        else $error("parity bit without enable");
    AST_PARITY_EVEN: assert property (reg_rd && serial_check_enable |=> !(^reg_rdata))
        else $error("word parity odd");
    AST_DRIVE_RSVD: assert property (reg_rd && reg_addr == 6'h1C |=> reg_rdata[14:11] == 4'h0
        && !reg_rdata[7] && !reg_rdata[3]) else $error("select spare bits set");
    AST_IDLE_OFF: assert property (!gen_enable |=> (gate_a | gate_b | gate_c) == 2'h0)
        else $error("gate on while idle");
    AST_NO_OVERLAP: assert property (!(gate_a.hs && gate_a.ls) && !(gate_b.hs && gate_b.ls)
        && !(gate_c.hs && gate_c.ls)) else $error("both sides on");

    // Main scenarios reached
    cover property (reg_rd ##1 reg_rvalid && reg_rdata[15]);
    cover property (!gate_b.hs ##1 gate_b.hs);
    cover property (gate_b.ls && gate_c.hs);
endmodule : pdr_top_monitor

bind pdr_top pdr_top_monitor #(.CNT_W(CNT_W)) pdr_top_monitor_inst (.clk_sys, .rstn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .serial_check_enable, .gen_enable, .gate_a, .gate_b, .gate_c);

`default_nettype wire

// file: sim/pdr_host.sv
`timescale 1ns/1ns
`default_nettype none

module pdr_host (
    // Clock and answer
    input wire logic clk_sys,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    // Requests
    output var logic [5:0] reg_addr,
    output var logic [15:0] reg_wdata,
    output var logic reg_wr,
    output var logic reg_rd
);
    // Quiet request lines from time zero
    initial begin
        reg_addr = 6'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Released lines show the inverse so a stale value never looks valid
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    // Answer comes one edge after the strobe is taken
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rvalid ? reg_rdata : 16'hXXXX;
    endtask : rd
endmodule : pdr_host

`default_nettype wire

// file: sim/pdr_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module pdr_top_tb_top;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic serial_check_enable = 1'b0;
    logic gen_enable = 1'b0;
    logic [5:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rdata, hs_b, ls_b, hs_c, ls_a;
    logic reg_wr, reg_rd, reg_rvalid;
    pdr_pkg::pdr_gate_type gate_a, gate_b, gate_c;
    int fails = 0;
    int num_checks = 0;
    // Phase B on-counts per select code over four periods of four clocks
    logic [15:0] exp_hs [8] = '{16'h0000, 16'h0000, 16'h0010, 16'h0000, 16'h0000, 16'h0000, 16'h0004, 16'h0004};
    logic [15:0] exp_ls [8] = '{16'h0000, 16'h0010, 16'h0000, 16'h0000, 16'h0000, 16'h0004, 16'h0000, 16'h000C};

    // 125 MHz clock
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    pdr_top #(.CNT_W(12)) pdr_top_inst (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .reg_rvalid, .serial_check_enable, .gen_enable, .gate_a, .gate_b, .gate_c);
    pdr_host pdr_host_inst (.clk_sys, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic rdchk(input logic [5:0] a, input logic [15:0] exp);
        pdr_host_inst.rd(a, rdata);
        chk("register word", rdata, exp);
    endtask : rdchk

    task automatic end_of_test();
        if (fails == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test

    // Register map first, then the generator per select code
    initial begin
        repeat (20) @(negedge clk_sys);
        rstn = 1'b1;
        rdchk(6'h1A, 16'h0000);
        rdchk(6'h1B, 16'h0000);
        rdchk(6'h1C, 16'h0777);
        serial_check_enable = 1'b1;
        rdchk(6'h1C, 16'h8777);
        pdr_host_inst.wr(6'h1A, 16'hFFFF);
        rdchk(6'h1A, 16'h0FFF);
        pdr_host_inst.wr(6'h1B, 16'h7ABC);
        rdchk(6'h1B, 16'h8ABC);
        pdr_host_inst.wr(6'h3F, 16'h1234);
        rdchk(6'h3F, 16'h0000);
        pdr_host_inst.wr(6'h1C, 16'hFFFF);
        rdchk(6'h1C, 16'h8777);
        pdr_host_inst.wr(6'h1C, 16'h0123);
        rdchk(6'h1C, 16'h0123);
        serial_check_enable = 1'b0;
        pdr_host_inst.wr(6'h18, 16'h0004);
        rdchk(6'h18, 16'h0004);
        pdr_host_inst.wr(6'h1A, 16'h0001);
        pdr_host_inst.wr(6'h1B, 16'h0003);
        gen_enable = 1'b1;
        for (int k = 0; k < 8; k++) begin
            pdr_host_inst.wr(6'h1C, 16'h0607 | (16'(k) << 4));
            rdchk(6'h1C, 16'h0607 | (16'(k) << 4));
            repeat (2) @(negedge clk_sys);
            hs_b = 16'h0000;
            ls_b = 16'h0000;
            hs_c = 16'h0000;
            ls_a = 16'h0000;
            repeat (16) begin
                @(negedge clk_sys);
                hs_b = hs_b + 16'(gate_b.hs);
                ls_b = ls_b + 16'(gate_b.ls);
                hs_c = hs_c + 16'(gate_c.hs);
                ls_a = ls_a + 16'(gate_a.ls);
            end
            chk("phase b high", hs_b, exp_hs[k]);
            chk("phase b low", ls_b, exp_ls[k]);
            chk("phase c high", hs_c, 16'h000C);
            chk("phase a low", ls_a, 16'h0010);
        end
        gen_enable = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("idle gates", {10'h000, gate_a, gate_b, gate_c}, 16'h0000);
        end_of_test();
    end
endmodule : pdr_top_tb_top

`default_nettype wire
